// file: logic/timer_pkg.sv
// shared types and constants for the capture/compare/pwm timer
// Overview of operation
// - one 16-bit counter shared by channels
// - four channels, each capture, compare or pwm
// - capture copies counter on input event
// - compare output follows counter versus threshold
// - pwm shape follows successive compare writes
// - dead-time insertion only in pwm mode, when HAS_DEAD_TIME is set
// - events go out to event router
// - count clock ticks or input events
package timer_pkg;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 4;
  localparam int DT_W = 8;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [DT_W-1:0] DT_RST = 8'h00;

  // channel mode, one-hot
  typedef enum logic [2:0] {
    MODE_CAPTURE = 3'b001,
    MODE_COMPARE = 3'b010,
    MODE_PWM = 3'b100
  } ch_mode_type;

  // per-channel software setup
  typedef struct packed {
    ch_mode_type mode;
    logic [CNT_W-1:0] value;
    logic value_wr;
    logic irq_en;
    logic flag_clr;
  } ch_cfg_type;

  // per-channel outputs
  typedef struct packed {
    logic [CNT_W-1:0] capture;
    logic out;
    logic out_n;
    logic flag;
    logic event_pulse;
  } ch_stat_type;
endpackage

// file: logic/timer_capture_compare_pwm.sv
// sixteen-bit timer with capture, compare and pwm channels
module timer_capture_compare_pwm import timer_pkg::*; #(
  parameter int CHANNELS = NUM_CH,
  parameter bit HAS_DEAD_TIME = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic count_events,
  input wire logic count_pin,
  input wire logic [CHANNELS-1:0] capture_pin,
  input wire logic [DT_W-1:0] dead_time,
  input wire ch_cfg_type [CHANNELS-1:0] ch_cfg,
  input wire logic ovf_clr,
  output ch_stat_type [CHANNELS-1:0] ch_stat,
  output logic [CNT_W-1:0] count,
  output logic ovf_flag,
  output logic ovf_event,
  output logic irq
);

  logic [CNT_W-1:0] cnt_r;
  logic ovf_r;
  logic ovf_ev_r;
  logic irq_r;
  logic [2:0] cnt_pin_s;
  logic [CHANNELS-1:0] cap_s1;
  logic [CHANNELS-1:0] cap_s2;
  logic [CHANNELS-1:0] cap_s3;
  logic tick;
  logic wrap;

  // pins pass two flops; third stage only feeds edge detection
  // [0] meets the pin, [1] is the first safe copy, [2] the last level
  // reset clears the chain to the idle low, so no false edge follows
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_pin_s <= 3'h0;
      cap_s1 <= '0;
      cap_s2 <= '0;
      cap_s3 <= '0;
    end else begin
      cnt_pin_s <= {cnt_pin_s[1:0], count_pin};
      cap_s1 <= capture_pin;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end

  // tick source select
  // an event edge counts once: cnt_pin_s[2] holds the previous level
  assign tick = run & (count_events ? (cnt_pin_s[1] & ~cnt_pin_s[2])
                                    : 1'b1);
  // wrap is the last tick before the counter rolls to zero
  assign wrap = tick & (cnt_r == CNT_MAX);

  // shared time base
  // up-count only; there is no load or direction control
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_r <= CNT_RST;
    end else if (tick) begin
      cnt_r <= cnt_r + 16'h0001; // rolls to zero past the top
    end
  end

  // sticky overflow, set wins over clear
  // ovf_ev_r is the one-cycle copy that goes out to the event router
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ovf_r <= 1'b0;
      ovf_ev_r <= 1'b0;
    end else begin
      ovf_r <= wrap | (ovf_r & ~ovf_clr);
      ovf_ev_r <= wrap;
    end
  end

  // masked flags feed the request; the flags stay visible unmasked
  logic [CHANNELS-1:0] flag_any;

  // identical channels, each in its own mode
  // CHANNELS may be cut to three for an instance with fewer outputs
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i++) begin : g_ch
      logic [CNT_W-1:0] thr_r;
      logic [CNT_W-1:0] buf_r;
      logic [CNT_W-1:0] cap_r;
      logic out_r;
      logic raw_r;
      logic outn_r;
      logic flag_r;
      logic ev_r;
      logic [DT_W-1:0] dt_r;
      logic cap_ev;
      logic match;
      logic hit;
      ch_mode_type md;

      assign md = ch_cfg[i].mode;
      assign cap_ev = cap_s2[i] & ~cap_s3[i];
      // a match needs a tick, so a stopped counter does not match again
      assign match = tick & (cnt_r == thr_r);
      // event source per mode; an unused mode code raises nothing
      always_comb begin
        case (md)
          MODE_CAPTURE: hit = cap_ev;
          MODE_COMPARE: hit = match;
          MODE_PWM: hit = match;
          default: hit = 1'b0;
        endcase
      end

      // buffered compare value loads at wrap so each period takes
      // the next written value without a glitch mid-period
      // compare mode takes a new threshold at once
      always_ff @(posedge core_clk) begin
        if (rst) begin
          thr_r <= CNT_RST;
          buf_r <= CNT_RST;
        end else begin
          if (ch_cfg[i].value_wr) begin
            buf_r <= ch_cfg[i].value;
          end
          if (md != MODE_PWM && ch_cfg[i].value_wr) begin
            thr_r <= ch_cfg[i].value;
          end else if (md == MODE_PWM && wrap) begin
            thr_r <= ch_cfg[i].value_wr ? ch_cfg[i].value : buf_r;
          end
        end
      end

      // latch counter on capture event
      // a capture edge while another mode is selected is dropped
      always_ff @(posedge core_clk) begin
        if (rst) begin
          cap_r <= CNT_RST;
        end else if (md == MODE_CAPTURE && cap_ev) begin
          cap_r <= cnt_r;
        end
      end

      // compare output is counter at or above threshold
      // two register stages, raw_r then out_r, so the pin never shows a compare glitch
      always_ff @(posedge core_clk) begin
        if (rst) begin
          raw_r <= 1'b0;
        end else begin
          case (md)
            MODE_COMPARE: raw_r <= (cnt_r >= thr_r);
            MODE_PWM: raw_r <= (cnt_r < thr_r); // high from period start
            MODE_CAPTURE: raw_r <= 1'b0;
            default: raw_r <= 1'b0;
          endcase
        end
      end

      // dead time delays each rising edge, in pwm mode and only with HAS_DEAD_TIME set
      // a change of raw_r, or both sides low as after reset, opens a gap
      always_ff @(posedge core_clk) begin
        if (rst) begin
          dt_r <= DT_RST;
          out_r <= 1'b0;
          outn_r <= 1'b0;
        end else if (HAS_DEAD_TIME && md == MODE_PWM) begin
          if (raw_r != out_r || raw_r == outn_r) begin
            // >= so a dead_time lowered mid-gap cannot run the count past it
            if (dt_r >= dead_time) begin
              dt_r <= DT_RST;
              out_r <= raw_r;
              outn_r <= ~raw_r;
            end else begin
              dt_r <= dt_r + 8'h01;
              out_r <= 1'b0; // both sides off during the gap
              outn_r <= 1'b0;
            end
          end
        end else begin
          // other modes, or no dead time here: raw_r passes straight out
          dt_r <= DT_RST;
          out_r <= raw_r;
          outn_r <= ~raw_r;
        end
      end

      // sticky flag, set wins over clear
      always_ff @(posedge core_clk) begin
        if (rst) begin
          flag_r <= 1'b0;
          ev_r <= 1'b0;
        end else begin
          flag_r <= hit | (flag_r & ~ch_cfg[i].flag_clr);
          ev_r <= hit;
        end
      end

      assign flag_any[i] = flag_r & ch_cfg[i].irq_en;
      // status leaves straight from the channel registers
      assign ch_stat[i].capture = cap_r;
      assign ch_stat[i].out = out_r;
      assign ch_stat[i].out_n = outn_r;
      assign ch_stat[i].flag = flag_r;
      assign ch_stat[i].event_pulse = ev_r;
    end
  endgenerate

  // combined request is registered
  // registered so the request does not glitch while flags change
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |flag_any;
    end
  end

  // every output is a register itself, no logic after the flop
  assign count = cnt_r;
  assign ovf_flag = ovf_r;
  assign ovf_event = ovf_ev_r;
  assign irq = irq_r;
endmodule

// file: testbench/timer_assertions.sv
// port-level checks for the capture/compare/pwm timer
module timer_assertions import timer_pkg::*; #(
  parameter int CHANNELS = NUM_CH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic count_events,
  input wire ch_cfg_type [CHANNELS-1:0] ch_cfg,
  input wire logic ovf_clr,
  input wire ch_stat_type [CHANNELS-1:0] ch_stat,
  input wire logic [CNT_W-1:0] count,
  input wire logic ovf_flag,
  input wire logic ovf_event,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // a free-running tick, and the tick that wraps
  sequence tick_s; run && !count_events; endsequence
  sequence wrap_s; tick_s ##0 count == CNT_MAX; endsequence
  chk_count_step: assert property (
    tick_s |=> count - $past(count) == 16'h0001) else $error("count step");
  chk_count_hold: assert property (
    !run |=> $stable(count)) else $error("count moved");
  chk_ovf_wrap: assert property (
    wrap_s |=> count == CNT_RST ##[0:1] ovf_event) else $error("no wrap");
  chk_ovf_sticky: assert property (
    ovf_flag && !ovf_clr |=> ovf_flag) else $error("ovf lost");
  chk_ovf_clear: assert property (
    ovf_clr |=> !ovf_flag || ovf_event) else $error("ovf not cleared");
  chk_flag_sticky: assert property (
    ch_stat[0].flag && !ch_cfg[0].flag_clr |=> ch_stat[0].flag)
    else $error("flag lost");
  chk_flag_clear: assert property (
    ch_cfg[0].flag_clr |=> !ch_stat[0].flag || ch_stat[0].event_pulse)
    else $error("flag not cleared");
  chk_irq_cause: assert property (
    ch_stat[0].flag && ch_cfg[0].irq_en |=> irq) else $error("irq missing");
  chk_cap_value: assert property (
    ch_cfg[0].mode == MODE_CAPTURE && ch_stat[0].event_pulse |->
    ch_stat[0].capture == $past(count)) else $error("capture value");
  // a flag only rises together with its event pulse
  chk_flag_event: assert property (
    $rose(ch_stat[1].flag) |-> ch_stat[1].event_pulse)
    else $error("flag without event");
  chk_out_pair: assert property (
    !(ch_stat[2].out && ch_stat[2].out_n)) else $error("both sides on");
endmodule
bind timer_capture_compare_pwm timer_assertions #(.CHANNELS(CHANNELS))
  u_timer_assertions (.*);

// file: testbench/event_pin_model.sv
// far-side event sources: each request becomes a clean pin level
module event_pin_model (
  input wire logic core_clk,
  input wire logic [4:0] fire,
  output logic [4:0] pin
);
  // launched from a flop so the sync stage sees glitch-free edges
  always_ff @(posedge core_clk) pin <= fire;
endmodule

// file: testbench/tb_timer_capture_compare_pwm.sv
// self-checking bench for the capture/compare/pwm timer
module tb_timer_capture_compare_pwm import timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0;
  logic rst = 1;
  logic run = 0;
  logic count_events = 0;
  logic ovf_clr = 0;
  logic [4:0] fire = '0;
  logic [4:0] pin;
  logic [DT_W-1:0] dead_time = '0;
  ch_cfg_type [NUM_CH-1:0] ch_cfg = '0;
  ch_stat_type [NUM_CH-1:0] ch_stat;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] exp;
  logic ovf_flag, ovf_event, irq;
  int mismatches = 0;
  int checked = 0;
  int n;
  int gap;
  always #25 core_clk = ~core_clk;
  event_pin_model u_event_pin_model (.core_clk(core_clk), .fire(fire),
    .pin(pin));
  timer_capture_compare_pwm u_timer_capture_compare_pwm (
    .core_clk(core_clk), .rst(rst), .run(run), .count_events(count_events),
    .count_pin(pin[4]), .capture_pin(pin[3:0]), .dead_time(dead_time),
    .ch_cfg(ch_cfg), .ovf_clr(ovf_clr), .ch_stat(ch_stat), .count(count),
    .ovf_flag(ovf_flag), .ovf_event(ovf_event), .irq(irq));
  // inputs always change 5 ns after the edge
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #5;
  endtask
  task automatic check(input string what, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait on a channel flag
  task automatic wait_flag(input int c, input int lim);
    for (n = 0; n < lim && ch_stat[c].flag !== 1'b1; n++) step(1);
    if (n == lim) begin
      mismatches++;
      give_verdict();
    end
  endtask
  initial begin
    void'($urandom(51));
    // every channel starts in capture mode, which raises no match flags
    for (int c = 0; c < NUM_CH; c++) ch_cfg[c].mode = MODE_CAPTURE;
    step(3);
    rst = 0;
    exp = CNT_RST;
    check("count", exp, count);
    for (int i = 0; i < 4; i++) begin
      n = $urandom_range(40, 1);
      run = 1;
      step(n);
      exp = exp + 16'(n);
      check("count", exp, count);
      run = 0;
      step(n % 3 + 1);
      check("hold", exp, count);
    end
    count_events = 1;
    run = 1;
    for (int i = 0; i < 3; i++) begin
      fire[4] = 1;
      step(2);
      fire[4] = 0;
      step(6);
    end
    exp = exp + 16'h0003;
    check("events", exp, count);
    run = 0;
    ch_cfg[0].mode = MODE_CAPTURE;
    ch_cfg[0].irq_en = 1;
    fire[0] = 1;
    step(2);
    fire[0] = 0;
    wait_flag(0, 20);
    check("capture", exp, ch_stat[0].capture);
    step(1);
    check("irq", 16'h0001, 16'(irq));
    ch_cfg[0].flag_clr = 1;
    step(1);
    ch_cfg[0].flag_clr = 0;
    step(1);
    check("flag_clr", 16'h0000, 16'(ch_stat[0].flag));
    check("irq_off", 16'h0000, 16'(irq));
    count_events = 0;
    ch_cfg[1] = '{MODE_COMPARE, exp + 16'($urandom_range(200, 20)),
      1'b1, 1'b0, 1'b0};
    ch_cfg[2] = '{MODE_PWM, 16'h0100, 1'b1, 1'b0, 1'b0};
    gap = $urandom_range(9, 2);
    dead_time = DT_W'(gap);
    step(1);
    ch_cfg[1].value_wr = 0;
    ch_cfg[2].value_wr = 0;
    step(2);
    check("cmp_low", 16'h0000, 16'(ch_stat[1].out));
    run = 1;
    wait_flag(1, 300);
    step(1);
    check("cmp_high", 16'h0001, 16'(ch_stat[1].out));
    // pwm threshold only takes effect after the wrap
    // then both sides stay low for dead_time cycles before out rises
    for (n = 0; n < 70000 && ovf_flag !== 1'b1; n++) step(1);
    if (n == 70000) begin
      mismatches++;
      give_verdict();
    end
    step(2);
    check("ovf", 16'h0001, 16'(ovf_flag));
    check("dt_gap", 16'h0000, 16'({ch_stat[2].out, ch_stat[2].out_n}));
    step(gap - 1);
    check("dt_hold", 16'h0000, 16'(ch_stat[2].out));
    step(1);
    check("pwm_high", 16'h0001, 16'(ch_stat[2].out));
    check("pwm_high_n", 16'h0000, 16'(ch_stat[2].out_n));
    ovf_clr = 1;
    step(1);
    ovf_clr = 0;
    step(1);
    check("ovf_clr", 16'h0000, 16'(ovf_flag));
    step(16'h0110);
    check("pwm_low", 16'h0000, 16'(ch_stat[2].out));
    check("pwm_low_n", 16'h0001, 16'(ch_stat[2].out_n));
    give_verdict();
  end
endmodule
